// File: ccw_pkg.sv
// Notes on behaviour
// R1 - Receive gain bits 2..0, volume bits 5..3, 111 mutes
// R2 - Transmit gain bits 2..0, bit 3 mutes transmit
// R3 - Sidetone: off, -12, -18 or -24 dB
// R4 - Transmit bits 5..4 select sidetone level
// R5 - Sidetone never follows receive volume or mute
// R6 - Mode bit 3 sends tones to DAC, else ringer
// R7 - Tone bits 2..0: off, six sine levels, square
// R8 - Tone bits 5..3 select one of eight frequencies
// R9 - Ringer off drives both ringer outputs low
// R10 - Ringer is 32 kHz pulse density, width sets volume
// R11 - Square volume gives full square wave on ringer
// R12 - After reset: standby, all settings zero
// R13 - Standby powers down all but host interface
// R14 - Host standby resets core, keeps settings
// R15 - Mode bit 2 is power, bits 1..0 loop select
// R16 - Active defaults to normal unless loop chosen
// R17 - Loop 1 returns compressed data to radio side
// R18 - Loop 1 feeds transmit filter to receive filter
// R19 - Loop 2 loops microphone through encoder and decoder
// R20 - Host holds reset at least ten clocks
// R21 - Internal reset ends 125 us after release
// R22 - External reset clears settings and resets core
// R23 - One byte per write: bits 7..6 group, 5..0 value
// R24 - Writes accepted in standby and in active
// R25 - Whole six-bit field stored, no read-back
// R26 - Loop bits ignored in standby, applied when active
package ccw_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ        = 250_000_000;
	localparam int unsigned RESET_TIME_NS = 125_000;
	// Least time, so rounded up
	localparam int unsigned RESET_CYCLES  =
		(RESET_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned PULSE_HZ      = 32_000;
	localparam int unsigned PULSE_CYCLES  = CLK_HZ / PULSE_HZ;

	// ****************************************
	// Control byte layout
	// ****************************************
	localparam int unsigned GRP_LSB       = 6;
	localparam logic [1:0]  GRP_MODE      = 2'h0;
	localparam logic [1:0]  GRP_RX        = 2'h1;
	localparam logic [1:0]  GRP_TX        = 2'h2;
	localparam logic [1:0]  GRP_TONE      = 2'h3;
	localparam logic [5:0]  SETTING_RST   = 6'h00;
	localparam logic [7:0]  BYTE_RST      = 8'h00;
	localparam int unsigned MODE_TONE_BIT = 3;
	localparam int unsigned MODE_PON_BIT  = 2;
	localparam logic [1:0]  LOOP_NORMAL   = 2'h0;
	localparam logic [1:0]  LOOP_ONE      = 2'h1;
	localparam logic [1:0]  LOOP_TWO      = 2'h2;
	localparam int unsigned FLD3_HI_LSB   = 3;
	localparam logic [2:0]  RX_VOL_MUTE   = 3'h7;
	localparam int unsigned TX_MUTE_BIT   = 3;
	localparam int unsigned TX_ST_LSB     = 4;
	localparam logic [2:0]  TONE_VOL_OFF  = 3'h0;
	localparam logic [2:0]  TONE_VOL_SQR  = 3'h7;

	// ****************************************
	// Carriers
	// ****************************************
	typedef enum logic [1:0] {ST_INIT, ST_STANDBY, ST_ACTIVE} ccw_state_t;

	typedef struct packed {
		logic [2:0] gain;
		logic [2:0] atten;
		logic       mute;
	} ccw_rx_t;

	typedef struct packed {
		logic [2:0] gain;
		logic       mute;
		logic [1:0] sidetone;
	} ccw_tx_t;

	typedef struct packed {
		logic       to_dac;
		logic [2:0] freq;
		logic [2:0] vol;
		logic       square;
	} ccw_tone_t;

	typedef struct packed {
		logic ready;
		logic active;
		logic core_reset;
		logic loop1;
		logic loop2;
	} ccw_mode_t;

	// ****************************************
	// Tables
	// ****************************************
	function automatic int unsigned tone_hz(input logic [2:0] code);
		case (code)
			3'h0: tone_hz = 400;
			3'h1: tone_hz = 421;
			3'h2: tone_hz = 444;
			3'h3: tone_hz = 800;
			3'h4: tone_hz = 1000;
			3'h5: tone_hz = 1067;
			3'h6: tone_hz = 1333;
			default: tone_hz = 2000;
		endcase
	endfunction

	function automatic int unsigned tone_half_cycles(
		input int unsigned clk_hz,
		input logic [2:0]  code);
		tone_half_cycles = clk_hz / (2 * tone_hz(code));
	endfunction

	// Pulse width in 128ths of a slot, roughly tracking the dB steps
	function automatic int unsigned pulse_128ths(input logic [2:0] vol);
		case (vol)
			3'h1: pulse_128ths = 2;
			3'h2: pulse_128ths = 5;
			3'h3: pulse_128ths = 9;
			3'h4: pulse_128ths = 18;
			3'h5: pulse_128ths = 36;
			3'h6: pulse_128ths = 64;
			default: pulse_128ths = 0;
		endcase
	endfunction

endpackage

// File: ccw_control_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module ccw_control_decoder
	import ccw_pkg::*;
#(
	parameter int unsigned P_CLK_HZ       = CLK_HZ,
	parameter int unsigned P_RESET_CYCLES = RESET_CYCLES,
	parameter int unsigned P_PULSE_CYCLES = PULSE_CYCLES
)
(
	// System clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst,
	// Host write link
	input  wire logic       i_clk_link,
	input  wire logic       i_link_wr_valid,
	input  wire logic [7:0] i_link_wr_byte,
	// Decoded settings
	output var  ccw_mode_t  o_mode,
	output var  ccw_rx_t    o_rx,
	output var  ccw_tx_t    o_tx,
	output var  ccw_tone_t  o_tone,
	// Ringer stage
	output logic            o_ringer_out_pos,
	output logic            o_ringer_out_neg
);

	// ****************************************
	// Link domain capture
	// ****************************************
	logic [7:0] link_byte_q;
	logic       link_tog_q;

	// Byte held stable until the next write; the toggle marks it
	always_ff @(posedge i_clk_link or posedge i_rst)
	begin
		if (i_rst)
		begin
			link_byte_q <= BYTE_RST;
			link_tog_q  <= 1'b0;
		end
		else if (i_link_wr_valid)
		begin
			link_byte_q <= i_link_wr_byte; // R23
			link_tog_q  <= ~link_tog_q;
		end
	end

	// ****************************************
	// Crossing into the system domain
	// ****************************************
	logic tog_s1_q;
	logic tog_s2_q;
	logic tog_s3_q;
	logic wr_evt;

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			tog_s1_q <= 1'b0;
			tog_s2_q <= 1'b0;
			tog_s3_q <= 1'b0;
		end
		else
		begin
			tog_s1_q <= link_tog_q;
			tog_s2_q <= tog_s1_q;
			tog_s3_q <= tog_s2_q;
		end
	end

	assign wr_evt = tog_s2_q ^ tog_s3_q;

	// ****************************************
	// Reset sequencing and power state
	// ****************************************
	ccw_state_t  state_q;
	ccw_state_t  state_d;
	logic [31:0] rst_cnt_q;
	logic [5:0]  mode_set_q;
	logic [5:0]  rx_set_q;
	logic [5:0]  tx_set_q;
	logic [5:0]  tone_set_q;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_INIT:
			begin
				if (rst_cnt_q == P_RESET_CYCLES - 1)
					state_d = ST_STANDBY; // R21
			end
			ST_STANDBY:
			begin
				if (mode_set_q[MODE_PON_BIT])
					state_d = ST_ACTIVE; // R15
			end
			ST_ACTIVE:
			begin
				if (!mode_set_q[MODE_PON_BIT])
					state_d = ST_STANDBY; // R14
			end
			default: state_d = ST_INIT;
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			state_q <= ST_INIT; // R12 R22
		else
			state_q <= state_d;
	end

	// Counts from release of the reset pin
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			rst_cnt_q <= 32'h0000_0000;
		else if (state_q == ST_INIT)
			rst_cnt_q <= rst_cnt_q + 32'h0000_0001; // R21
	end

	// ****************************************
	// Setting registers
	// ****************************************
	// Writes during the internal reset are dropped: not yet ready
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			mode_set_q <= SETTING_RST; // R12 R22
			rx_set_q   <= SETTING_RST;
			tx_set_q   <= SETTING_RST;
			tone_set_q <= SETTING_RST;
		end
		else if (wr_evt && state_q != ST_INIT) // R24
		begin
			case (link_byte_q[7:GRP_LSB]) // R23
				GRP_MODE: mode_set_q <= link_byte_q[5:0]; // R25
				GRP_RX:   rx_set_q   <= link_byte_q[5:0];
				GRP_TX:   tx_set_q   <= link_byte_q[5:0];
				GRP_TONE: tone_set_q <= link_byte_q[5:0];
				default:  mode_set_q <= mode_set_q;
			endcase
		end
	end

	// ****************************************
	// Mode outputs
	// ****************************************
	logic is_active;
	logic [1:0] loop_sel;

	assign is_active = (state_q == ST_ACTIVE);
	assign loop_sel  = mode_set_q[1:0];

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			o_mode <= '{ready: 1'b0, active: 1'b0, core_reset: 1'b1,
				loop1: 1'b0, loop2: 1'b0};
		else
		begin
			o_mode.ready      <= (state_q != ST_INIT); // R21
			o_mode.active     <= is_active; // R13
			// Core held in reset outside active mode
			o_mode.core_reset <= !is_active; // R13 R14 R22
			// Loop 1 covers both the compressed and linear loops
			o_mode.loop1      <= is_active
				&& loop_sel == LOOP_ONE; // R16 R17 R18 R26
			o_mode.loop2      <= is_active
				&& loop_sel == LOOP_TWO; // R19 R26
		end
	end

	// ****************************************
	// Path settings
	// ****************************************
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_rx   <= '0;
			o_tx   <= '0;
			o_tone <= '0;
		end
		else
		begin
			o_rx.gain    <= rx_set_q[2:0]; // R1
			o_rx.atten   <= rx_set_q[5:FLD3_HI_LSB];
			o_rx.mute    <= (rx_set_q[5:FLD3_HI_LSB] == RX_VOL_MUTE); // R1
			o_tx.gain    <= tx_set_q[2:0]; // R2
			o_tx.mute    <= tx_set_q[TX_MUTE_BIT]; // R2
			// Taken from the transmit byte only
			o_tx.sidetone <= tx_set_q[5:TX_ST_LSB]; // R3 R4 R5
			o_tone.to_dac <= mode_set_q[MODE_TONE_BIT]; // R6
			o_tone.freq   <= tone_set_q[5:FLD3_HI_LSB]; // R8
			o_tone.vol    <= tone_set_q[2:0]; // R7
			o_tone.square <= (tone_set_q[2:0] == TONE_VOL_SQR); // R7
		end
	end

	// ****************************************
	// Ringer tone generator
	// ****************************************
	logic        ring_en;
	logic [2:0]  tone_vol;
	logic [2:0]  tone_freq;
	logic [31:0] half_cycles;
	logic [31:0] pulse_width;
	logic [31:0] tone_cnt_q;
	logic [31:0] pulse_cnt_q;
	logic        phase_q;
	logic        pulse_on;

	assign tone_vol    = tone_set_q[2:0];
	assign tone_freq   = tone_set_q[5:FLD3_HI_LSB];
	assign half_cycles = tone_half_cycles(P_CLK_HZ, tone_freq); // R8
	assign pulse_width = (P_PULSE_CYCLES * pulse_128ths(tone_vol)) / 128;
	assign pulse_on    = (pulse_cnt_q < pulse_width); // R10
	// Ringer only runs when active, routed to it, and not off
	assign ring_en     = is_active && !mode_set_q[MODE_TONE_BIT]
		&& tone_vol != TONE_VOL_OFF; // R6 R7 R13

	// Tone phase: half-period counter
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			tone_cnt_q <= 32'h0000_0000;
			phase_q    <= 1'b0;
		end
		else if (!ring_en)
		begin
			tone_cnt_q <= 32'h0000_0000;
			phase_q    <= 1'b0;
		end
		else if (tone_cnt_q >= half_cycles - 1)
		begin
			tone_cnt_q <= 32'h0000_0000;
			phase_q    <= ~phase_q; // R8
		end
		else
			tone_cnt_q <= tone_cnt_q + 32'h0000_0001;
	end

	// Pulse slots at the basic pulse rate
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			pulse_cnt_q <= 32'h0000_0000;
		else if (!ring_en || pulse_cnt_q == P_PULSE_CYCLES - 1)
			pulse_cnt_q <= 32'h0000_0000; // R10
		else
			pulse_cnt_q <= pulse_cnt_q + 32'h0000_0001;
	end

	// Each half of the tone drives one side; the other stays low
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_ringer_out_pos <= 1'b0;
			o_ringer_out_neg <= 1'b0;
		end
		else if (!ring_en)
		begin
			o_ringer_out_pos <= 1'b0; // R9
			o_ringer_out_neg <= 1'b0; // R9
		end
		else if (tone_vol == TONE_VOL_SQR)
		begin
			o_ringer_out_pos <= phase_q; // R11
			o_ringer_out_neg <= ~phase_q; // R11
		end
		else
		begin
			o_ringer_out_pos <= phase_q & pulse_on; // R10
			o_ringer_out_neg <= ~phase_q & pulse_on; // R10
		end
	end

endmodule
`default_nettype wire

// File: ccw_checker_props.sv
`timescale 1ns/1ps
`default_nettype none
module ccw_checker
	import ccw_pkg::*;
#(
	parameter int unsigned P_RESET_CYCLES = RESET_CYCLES
)
(
	// Clock and reset
	input  wire logic      i_clk_sys,
	input  wire logic      i_rst,
	// Watched outputs
	input  wire ccw_mode_t o_mode,
	input  wire ccw_rx_t   o_rx,
	input  wire ccw_tone_t o_tone,
	input  wire logic      o_ringer_out_pos,
	input  wire logic      o_ringer_out_neg
);
	// ****
	// Cycles since reset release, saturating
	// ****
	logic [15:0] n_q;

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			n_q <= 16'h0000;
		else if (n_q != 16'hffff)
			n_q <= n_q + 16'h0001;
	end

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	chk_ready_time: assert property (
		$rose(o_mode.ready) |-> n_q >= P_RESET_CYCLES
			&& n_q <= P_RESET_CYCLES + 4)
		else $error("ready rose at wrong time");
	chk_ready_holds: assert property (
		o_mode.ready |=> o_mode.ready)
		else $error("ready dropped");
	chk_core_rst: assert property (
		o_mode.core_reset == !o_mode.active)
		else $error("core reset not tied to standby");
	chk_loop_act: assert property (
		(o_mode.loop1 || o_mode.loop2) |-> o_mode.active)
		else $error("loop shown in standby");
	chk_loop_excl: assert property (
		!(o_mode.loop1 && o_mode.loop2))
		else $error("both loops set");
	chk_rx_mute: assert property (
		o_rx.mute == (o_rx.atten == RX_VOL_MUTE))
		else $error("rx mute flag wrong");
	chk_tone_sqr: assert property (
		o_tone.square == (o_tone.vol == TONE_VOL_SQR))
		else $error("square flag wrong");
	chk_ring_low: assert property (
		(!o_mode.active || o_tone.to_dac
			|| o_tone.vol == TONE_VOL_OFF)[*3]
		|-> !o_ringer_out_pos && !o_ringer_out_neg)
		else $error("ringer driven while off");
	chk_ring_sqr: assert property (
		(o_mode.active && !o_tone.to_dac && o_tone.square)[*4]
		|-> o_ringer_out_pos != o_ringer_out_neg)
		else $error("square ringer not differential");
endmodule

bind ccw_control_decoder ccw_checker #(
	.P_RESET_CYCLES(P_RESET_CYCLES)
) i_ccw_checker (
	.i_clk_sys       (i_clk_sys),
	.i_rst           (i_rst),
	.o_mode          (o_mode),
	.o_rx            (o_rx),
	.o_tone          (o_tone),
	.o_ringer_out_pos(o_ringer_out_pos),
	.o_ringer_out_neg(o_ringer_out_neg)
);
`default_nettype wire

// File: ccw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccw_host_model
(
	// Link to the decoder
	output logic       o_clk_link,
	output logic       o_wr_valid,
	output logic [7:0] o_wr_byte
);
	initial
	begin
		o_clk_link = 1'b0;
		o_wr_valid = 1'b0;
		o_wr_byte  = 8'h00;
	end

	// Link clock only runs while a task ticks it: in a write frame or during reset
	task automatic tick(input int n);
		repeat (n)
		begin
			#3 o_clk_link = 1'b1;
			#3 o_clk_link = 1'b0;
		end
	endtask

	// Byte held five more link cycles so the sync sees it stable
	task automatic send(input logic [7:0] b);
		o_wr_valid = 1'b1;
		o_wr_byte  = b;
		#3 o_clk_link = 1'b1;
		#1 o_wr_valid = 1'b0;
		#2 o_clk_link = 1'b0;
		tick(5);
		o_wr_byte = ~b;
	endtask
endmodule
`default_nettype wire

// File: codec_control_word_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module codec_control_word_decoder_tb;
	import ccw_pkg::*;
	localparam int unsigned HZ = 2_500_000;
	logic      i_clk_sys;
	logic      i_rst;
	logic      clk_link;
	logic      wr_valid;
	logic [7:0] wr_byte;
	ccw_mode_t o_mode;
	ccw_rx_t   o_rx;
	ccw_tx_t   o_tx;
	ccw_tone_t o_tone;
	logic      pos;
	logic      neg;
	int        n_mismatch;
	int        checks_done;
	int        n;

	ccw_host_model i_ccw_host_model (
		.o_clk_link(clk_link),
		.o_wr_valid(wr_valid),
		.o_wr_byte (wr_byte)
	);
	ccw_control_decoder #(
		.P_CLK_HZ      (HZ),
		.P_RESET_CYCLES(20),
		.P_PULSE_CYCLES(64)
	) i_ccw_control_decoder (
		.i_clk_sys       (i_clk_sys),
		.i_rst           (i_rst),
		.i_clk_link      (clk_link),
		.i_link_wr_valid (wr_valid),
		.i_link_wr_byte  (wr_byte),
		.o_mode          (o_mode),
		.o_rx            (o_rx),
		.o_tx            (o_tx),
		.o_tone          (o_tone),
		.o_ringer_out_pos(pos),
		.o_ringer_out_neg(neg)
	);

	// ****
	// Helpers
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] b);
		@(negedge i_clk_sys);
		i_ccw_host_model.send(b);
		repeat (8) @(negedge i_clk_sys);
	endtask

	// Length of the next high pulse on one ringer side
	task automatic hi_len(input bit sel, output int len);
		len = 0;
		for (int k = 0; k < 4000 && (sel ? pos : neg) !== 1'b0; k++)
			@(negedge i_clk_sys);
		for (int k = 0; k < 4000 && (sel ? pos : neg) !== 1'b1; k++)
			@(negedge i_clk_sys);
		while ((sel ? pos : neg) === 1'b1 && len < 4000)
		begin
			len++;
			@(negedge i_clk_sys);
		end
	endtask

	task automatic do_reset;
		i_rst = 1'b1;
		i_ccw_host_model.tick(12);
		repeat (10) @(negedge i_clk_sys);
		check(32'(o_mode), 32'h04);
		i_rst = 1'b0;
		for (int k = 0; k < 200 && o_mode.ready !== 1'b1; k++)
			@(negedge i_clk_sys);
		check(32'(o_mode), 32'h14);
		check(32'({o_rx, o_tx, o_tone}), 32'h0);
		$display("test reset done");
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_paths;
		for (int i = 0; i < 8; i++)
		begin
			wr({2'b01, 6'(i * 9)});
			check(32'(o_rx), 32'({i[2:0], i[2:0], i == 7}));
			wr({2'b10, i[1:0], i[0], i[2:0]});
			check(32'(o_tx), 32'({i[2:0], i[0], i[1:0]}));
		end
		wr(8'h78);
		check(32'(o_tx.sidetone), 32'h3);
		$display("test paths done");
	endtask

	task automatic t_mode;
		wr(8'h01);
		check(32'(o_mode), 32'h14);
		wr(8'h05);
		check(32'(o_mode), 32'h1a);
		wr(8'h06);
		check(32'(o_mode), 32'h19);
		wr(8'h04);
		check(32'(o_mode), 32'h18);
		wr(8'h00);
		check(32'(o_mode), 32'h14);
		check(32'(o_rx), 32'h0f);
		$display("test mode done");
	endtask

	task automatic t_ring;
		wr(8'h04);
		wr(8'hff);
		check(32'(o_tone), 32'h7f);
		hi_len(1'b1, n);
		check(n, HZ / 4000);
		// Off first: counters restart, so no pulse is cut by a phase edge
		wr(8'he0);
		check(32'({pos, neg}), 32'h0);
		wr(8'he6);
		check(32'(o_tone), 32'h4c);
		hi_len(1'b0, n);
		check(n, 32);
		wr(8'he0);
		check(32'({pos, neg}), 32'h0);
		wr(8'he7);
		wr(8'h0c);
		check(32'({o_tone.to_dac, pos, neg}), 32'h4);
		$display("test ring done");
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end

	// Whole run is about 8 us
	initial
	begin
		#150_000;
		n_mismatch++;
		conclude;
	end

	initial
	begin
		n_mismatch  = 0;
		checks_done = 0;
		i_rst       = 1'b1;
		do_reset;
		t_paths;
		t_mode;
		t_ring;
		do_reset;
		conclude;
	end
endmodule
`default_nettype wire
